// file: hdl/hpsd_host_port_strap_decode.v
`timescale 1ns/100ps
`include "hpsd_regs.vh"
// Overview of operation
// [RULE1] Class strap high parallel, low serial
// [RULE2] Width straps pick 8, 16, 9, 18 bits
// [RULE3] Wire strap picks 3-line or 4-line serial
// [RULE4] Active-low chip reset resets whole device
// [RULE5] Pins ignored while chip select high
// [RULE6] Data/command high data, low command
// [RULE7] Serial mode: data/command pin is clock
// [RULE8] 4-line: write strobe pin becomes data/command
// [RULE9] Read strobe drives data, write strobe captures
// [RULE10] Serial uses bit 0 only, ignores rest
// [RULE11] Tearing sync output off until enabled
// [RULE12] Sync line strap: 162 low, 160 high; reduced panel always gets 160
// [RULE13] Oscillator monitor output, ground when off
// [RULE14] Extended strap high enables full commands
// [RULE15] Panel strap 000 full, 011 reduced
// [RULE16] Source scan reverse picks direction
// [RULE17] Gate scan reverse picks direction
// [RULE18] Filter swap: RGB or BGR order
// [RULE19] Polarity strap: white or black panel
// [RULE20] Gamma strap picks built-in gamma set
// [RULE21] Straps latched once after reset release
module hpsd_host_port_strap_decode (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        sys_rst,
    // Host pins
    input  wire        chip_reset_n,
    input  wire        chip_select_n,
    input  wire        data_command_select,
    input  wire        read_strobe_n,
    input  wire        write_strobe_n,
    input  wire [17:0] dataIn,
    output reg  [17:0] dataOut,
    output reg  [17:0] dataOe,
    // Strap pins
    input  wire        interface_class_strap,
    input  wire        parallel_width_strap_hi,
    input  wire        parallel_width_strap_lo,
    input  wire        serial_wire_count_strap,
    input  wire        sync_line_count_strap,
    input  wire        extended_command_enable,
    input  wire [2:0]  panel_size_strap,
    input  wire        source_scan_reverse,
    input  wire        gate_scan_reverse,
    input  wire        filter_order_swap,
    input  wire        liquid_crystal_polarity,
    input  wire        gamma_curve_strap,
    // Core side: control from command logic
    input  wire        tearingEnable,
    input  wire        tearingLevel,
    input  wire        oscMonEnable,
    input  wire        oscClkLevel,
    input  wire [17:0] readData,
    input  wire        readDataValid,
    // Core side: received transfers
    output reg  [17:0] xferWord,
    output reg         xferIsData,
    output reg         xferValid,
    output reg         xferReadReq,
    // Outputs to pins
    output reg         tearing_sync_out,
    output reg         oscMonOut,
    // Decoded configuration
    output reg  [2:0]  busMode_r,
    output reg         extCmdEn_r,
    output reg         panelReduced_r,
    output reg  [8:0]  srcFirst_r,
    output reg  [8:0]  srcLast_r,
    output reg  [7:0]  gateFirst_r,
    output reg  [7:0]  gateLast_r,
    output reg  [7:0]  syncLines_r,
    output reg         bgrOrder_r,
    output reg         normBlack_r,
    output reg  [4:0]  gammaEntry0_r,
    output reg  [4:0]  gammaEntry1_r,
    output reg         cfgValid_r
);
    // Synchronised pins
    wire [17:0] dataS;
    wire        rstnS;
    wire        csnS;
    wire        dcS;
    wire        rdnS;
    wire        wrnS;
    wire [13:0] strapS;

    hpsd_sync2 #(.W(37)) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn ({dataIn, chip_reset_n, chip_select_n, data_command_select,
                   read_strobe_n, write_strobe_n, interface_class_strap,
                   parallel_width_strap_hi, parallel_width_strap_lo,
                   serial_wire_count_strap, sync_line_count_strap,
                   extended_command_enable, panel_size_strap,
                   source_scan_reverse, gate_scan_reverse, filter_order_swap,
                   liquid_crystal_polarity, gamma_curve_strap}),
        .syncOut ({dataS, rstnS, csnS, dcS, rdnS, wrnS, strapS})
    );

    // Whole-device reset: block reset or pin reset
    wire devRst = sys_rst | ~rstnS; // [RULE4]

    // Width mask for the parallel modes
    function [17:0] widthMask;
        input [2:0] mode;
        begin
            case (mode)
                `HPSD_MODE_PAR8:  widthMask = 18'h000FF;
                `HPSD_MODE_PAR16: widthMask = 18'h0FFFF;
                `HPSD_MODE_PAR9:  widthMask = 18'h001FF;
                `HPSD_MODE_PAR18: widthMask = 18'h3FFFF;
                default:          widthMask = 18'h00001;
            endcase
        end
    endfunction

    // Strap latch: waits a few clocks after release, then captures once
    reg [3:0] settleCnt_r;
    wire      isPar    = busMode_r[2];
    wire      isSer4   = (busMode_r == `HPSD_MODE_SER4);
    wire      fullPan  = (strapS[7:5] == `HPSD_PANEL_FULL);
    always @(posedge sys_clk) begin
        if (devRst) begin
            settleCnt_r    <= 4'h0;
            cfgValid_r     <= 1'b0;
            busMode_r      <= `HPSD_MODE_SER3;
            extCmdEn_r     <= 1'b0;
            panelReduced_r <= 1'b0;
            srcFirst_r     <= `HPSD_SRC_FULL_FIRST;
            srcLast_r      <= `HPSD_SRC_FULL_LAST;
            gateFirst_r    <= `HPSD_GATE_FULL_FIRST;
            gateLast_r     <= `HPSD_GATE_FULL_LAST;
            syncLines_r    <= `HPSD_SYNC_LINES_162;
            bgrOrder_r     <= 1'b0;
            normBlack_r    <= 1'b0;
            gammaEntry0_r  <= `HPSD_GAMMA_1_0;
            gammaEntry1_r  <= `HPSD_GAMMA_2_5;
        end else if (!cfgValid_r) begin
            if (settleCnt_r != `HPSD_STRAP_SETTLE) begin
                settleCnt_r <= settleCnt_r + 4'h1;
            end else begin
                cfgValid_r <= 1'b1; // [RULE21]
                if (strapS[13]) begin
                    busMode_r <= {1'b1, strapS[12], strapS[11]}; // [RULE1] [RULE2]
                end else begin
                    busMode_r <= strapS[10] ? `HPSD_MODE_SER4 : `HPSD_MODE_SER3; // [RULE3]
                end
                extCmdEn_r     <= strapS[8]; // [RULE14]
                panelReduced_r <= ~fullPan; // [RULE15]
                // Reverse direction swaps first and last index
                if (fullPan) begin
                    srcFirst_r  <= strapS[4] ? `HPSD_SRC_FULL_LAST : `HPSD_SRC_FULL_FIRST; // [RULE16]
                    srcLast_r   <= strapS[4] ? `HPSD_SRC_FULL_FIRST : `HPSD_SRC_FULL_LAST;
                    gateFirst_r <= strapS[3] ? `HPSD_GATE_FULL_LAST : `HPSD_GATE_FULL_FIRST; // [RULE17]
                    gateLast_r  <= strapS[3] ? `HPSD_GATE_FULL_FIRST : `HPSD_GATE_FULL_LAST;
                    syncLines_r <= strapS[9] ? `HPSD_SYNC_LINES_160 : `HPSD_SYNC_LINES_162; // [RULE12]
                end else begin
                    srcFirst_r  <= strapS[4] ? `HPSD_SRC_RED_LAST : `HPSD_SRC_RED_FIRST; // [RULE16]
                    srcLast_r   <= strapS[4] ? `HPSD_SRC_RED_FIRST : `HPSD_SRC_RED_LAST;
                    gateFirst_r <= strapS[3] ? `HPSD_GATE_RED_LAST : `HPSD_GATE_RED_FIRST; // [RULE17]
                    gateLast_r  <= strapS[3] ? `HPSD_GATE_RED_FIRST : `HPSD_GATE_RED_LAST;
                    // Line strap only counts for the full panel
                    syncLines_r <= `HPSD_SYNC_LINES_160;
                end
                bgrOrder_r    <= strapS[2]; // [RULE18]
                normBlack_r   <= strapS[1]; // [RULE19]
                gammaEntry0_r <= strapS[0] ? `HPSD_GAMMA_2_2 : `HPSD_GAMMA_1_0; // [RULE20]
                gammaEntry1_r <= strapS[0] ? `HPSD_GAMMA_1_8 : `HPSD_GAMMA_2_5;
            end
        end
    end

    // Pin role remap per mode
    wire selected = ~csnS & cfgValid_r;        // [RULE5]
    wire serClk   = dcS;                       // [RULE7]
    wire serDc    = isSer4 ? wrnS : 1'b0;      // [RULE8]
    wire serIn    = dataS[0];                  // [RULE10]

    // Edge history of strobes and serial clock
    reg wrnD_r;
    reg rdnD_r;
    reg sclD_r;
    always @(posedge sys_clk) begin
        if (devRst) begin
            wrnD_r <= 1'b1;
            rdnD_r <= 1'b1;
            sclD_r <= 1'b0;
        end else begin
            wrnD_r <= wrnS;
            rdnD_r <= rdnS;
            sclD_r <= serClk;
        end
    end
    wire wrRise  = wrnS & ~wrnD_r;
    wire rdFall  = ~rdnS & rdnD_r;
    wire rdRise  = rdnS & ~rdnD_r;
    wire sclRise = serClk & ~sclD_r;
    wire sclFall = ~serClk & sclD_r;

    // Serial shifter: 3-line has a leading d/c bit, 4-line samples the pin
    reg [8:0] shift_r;
    reg [3:0] bitCnt_r;
    reg       serRead_r;
    reg       serDrive_r;
    reg [7:0] serOut_r;
    wire [3:0] frameBits = isSer4 ? 4'h8 : 4'h9;
    always @(posedge sys_clk) begin
        if (devRst) begin
            shift_r     <= 9'h000;
            bitCnt_r    <= 4'h0;
            xferWord    <= 18'h00000;
            xferIsData  <= 1'b0;
            xferValid   <= 1'b0;
            xferReadReq <= 1'b0;
            serRead_r   <= 1'b0;
            serDrive_r  <= 1'b0;
            serOut_r    <= 8'h00;
        end else begin
            xferValid   <= 1'b0;
            xferReadReq <= 1'b0;
            if (!selected) begin
                // Deselect aborts a partial serial frame
                bitCnt_r   <= 4'h0;
                serDrive_r <= 1'b0;
                serRead_r  <= 1'b0;
            end else if (isPar) begin
                if (wrRise) begin
                    xferWord   <= dataS & widthMask(busMode_r); // [RULE9]
                    xferIsData <= dcS;                          // [RULE6]
                    xferValid  <= 1'b1;
                end
                if (rdFall) begin
                    xferReadReq <= 1'b1; // [RULE9]
                end
            end else begin
                if (serRead_r && sclFall) begin
                    serDrive_r <= 1'b1;
                    serOut_r   <= {serOut_r[6:0], 1'b0};
                end
                if (readDataValid && serRead_r) begin
                    serOut_r <= readData[7:0];
                end
                if (sclRise && !serDrive_r) begin
                    shift_r <= {shift_r[7:0], serIn};
                    if (bitCnt_r == frameBits - 4'h1) begin
                        bitCnt_r   <= 4'h0;
                        xferWord   <= {10'h000, shift_r[6:0], serIn};
                        xferIsData <= isSer4 ? serDc : shift_r[7]; // [RULE6] [RULE8]
                        xferValid  <= 1'b1;
                    end else begin
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end
                end
            end
        end
    end

    // Pin drivers; read data only while selected and strobe low
    always @(posedge sys_clk) begin
        if (devRst) begin
            dataOut          <= 18'h00000;
            dataOe           <= 18'h00000;
            tearing_sync_out <= 1'b0;
            oscMonOut        <= 1'b0;
        end else begin
            if (selected && isPar && !rdnS && !rdRise) begin
                dataOe  <= widthMask(busMode_r); // [RULE9]
                dataOut <= readData & widthMask(busMode_r);
            end else if (selected && !isPar && serDrive_r) begin
                dataOe  <= 18'h00001; // [RULE10]
                dataOut <= {17'h00000, serOut_r[7]};
            end else begin
                dataOe  <= 18'h00000;
                dataOut <= 18'h00000;
            end
            tearing_sync_out <= tearingEnable & tearingLevel; // [RULE11]
            oscMonOut        <= oscMonEnable & oscClkLevel;   // [RULE13]
        end
    end
endmodule

// file: hdl/hpsd_regs.vh
`ifndef HPSD_REGS_VH
`define HPSD_REGS_VH
// Data bus width on the pins
`define HPSD_DATA_W          18
// Decoded mode codes for busMode_r
`define HPSD_MODE_SER3       3'h0
`define HPSD_MODE_SER4       3'h1
`define HPSD_MODE_PAR8       3'h4
`define HPSD_MODE_PAR16      3'h5
`define HPSD_MODE_PAR9       3'h6
`define HPSD_MODE_PAR18      3'h7
// Panel size strap codes
`define HPSD_PANEL_FULL      3'h0
`define HPSD_PANEL_REDUCED   3'h3
// Source ranges are 9-bit values, gate ranges 8-bit values
`define HPSD_SRC_FULL_FIRST  9'h001
`define HPSD_SRC_FULL_LAST   9'h18C
`define HPSD_SRC_RED_FIRST   9'h007
`define HPSD_SRC_RED_LAST    9'h186
`define HPSD_GATE_FULL_FIRST 8'h01
`define HPSD_GATE_FULL_LAST  8'hA2
`define HPSD_GATE_RED_FIRST  8'h02
`define HPSD_GATE_RED_LAST   8'hA1
// Sync line counts
`define HPSD_SYNC_LINES_162  8'hA2
`define HPSD_SYNC_LINES_160  8'hA0
// Gamma entries in tenths
`define HPSD_GAMMA_1_0       5'h0A
`define HPSD_GAMMA_2_5       5'h19
`define HPSD_GAMMA_2_2       5'h16
`define HPSD_GAMMA_1_8       5'h12
// Clocks after reset release before straps are latched
`define HPSD_STRAP_SETTLE    4'h4
`endif

// file: hdl/hpsd_sync2.v
`timescale 1ns/100ps
// Two-flop synchroniser for a vector of pins
module hpsd_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         sys_rst,
    // Data
    input  wire [W-1:0] asyncIn,
    output reg  [W-1:0] syncOut
);
    reg [W-1:0] meta_r;

    // First stage feeds only the second
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_r  <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule

// file: testbench/hpsd_checker.sv
`timescale 1ns/100ps
module hpsd_checker (
    // Clock and reset
    input wire        sys_clk,
    input wire        sys_rst,
    // Pins and core controls
    input wire        chip_select_n,
    input wire        tearingEnable,
    input wire        oscMonEnable,
    input wire        interface_class_strap,
    input wire        sync_line_count_strap,
    input wire        gamma_curve_strap,
    // Outputs
    input wire [17:0] dataOe,
    input wire [17:0] xferWord,
    input wire        xferIsData,
    input wire        xferValid,
    input wire        xferReadReq,
    input wire        tearing_sync_out,
    input wire        oscMonOut,
    input wire [2:0]  busMode_r,
    input wire        panelReduced_r,
    input wire [7:0]  syncLines_r,
    input wire [4:0]  gammaEntry0_r,
    input wire        cfgValid_r
);
    reg [3:0] csHigh_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Cycles since deselect, saturating; latency of the last transfer fits inside
    always @(posedge sys_clk) begin
        if (sys_rst || !chip_select_n) csHigh_r <= 4'h0;
        else if (csHigh_r != 4'h8) csHigh_r <= csHigh_r + 4'h1;
    end

    a_oe_parallel: assert property (|dataOe |-> busMode_r[2] && cfgValid_r)
        else $error("bus driven outside parallel");
    a_tear_gated: assert property (!tearingEnable |=> !tearing_sync_out)
        else $error("tearing output while off");
    a_osc_ground: assert property (!oscMonEnable |=> !oscMonOut)
        else $error("monitor not grounded");
    a_cs_blocks: assert property (csHigh_r == 4'h8 |-> !xferValid && !xferReadReq)
        else $error("transfer while deselected");
    a_narrow_word: assert property (xferValid && (!busMode_r[2] || busMode_r[1:0] == 2'h0) |-> xferWord[17:8] == 10'h000)
        else $error("byte transfer too wide");
    a_mode_class: assert property (cfgValid_r |-> busMode_r[2] == interface_class_strap)
        else $error("class mismatch");
    a_sync_lines: assert property (cfgValid_r |-> syncLines_r == ((panelReduced_r || sync_line_count_strap) ? 8'hA0 : 8'hA2))
        else $error("sync line count wrong");
    a_gamma_set: assert property (cfgValid_r |-> gammaEntry0_r == (gamma_curve_strap ? 5'h16 : 5'h0A))
        else $error("gamma entry wrong");

    c_data_xfer: cover property (xferValid && xferIsData);
    c_read: cover property (xferReadReq);
    c_ser4: cover property (xferValid && busMode_r == 3'h1);
endmodule

bind hpsd_host_port_strap_decode hpsd_checker i_chk (.sys_clk, .sys_rst, .chip_select_n, .tearingEnable,
    .oscMonEnable, .interface_class_strap, .sync_line_count_strap, .gamma_curve_strap, .dataOe, .xferWord, .xferIsData,
    .xferValid, .xferReadReq, .tearing_sync_out, .oscMonOut, .busMode_r, .panelReduced_r, .syncLines_r,
    .gammaEntry0_r, .cfgValid_r);

// file: testbench/hpsd_host_model.sv
`timescale 1ns/100ps
// Microcontroller side of the host pins
module hpsd_host_model (
    // Clock
    input  wire        sys_clk,
    // Host pins
    output reg         chip_select_n,
    output reg         data_command_select,
    output reg         read_strobe_n,
    output reg         write_strobe_n,
    output reg  [17:0] dataIn
);
    // Idle: deselected, strobes high, serial clock low
    initial {chip_select_n, data_command_select, read_strobe_n, write_strobe_n, dataIn} = 22'h2C0000;

    // Parallel cycle; strobe low and high for several clocks to clear the synchroniser
    task par(input [17:0] w, input dc, input rd, input sel);
        begin
            @(posedge sys_clk);
            chip_select_n <= ~sel;
            data_command_select <= dc;
            dataIn <= w;
            @(posedge sys_clk);
            if (rd) read_strobe_n <= 1'b0;
            else write_strobe_n <= 1'b0;
            repeat (6) @(posedge sys_clk);
            {read_strobe_n, write_strobe_n} <= 2'b11;
            repeat (4) @(posedge sys_clk);
            chip_select_n <= 1'b1;
            dataIn <= ~w; // Released bus must not look stable
        end
    endtask

    // Serial frame, MSB first on bit 0, noise on unused bits
    task ser(input [8:0] b, input [3:0] n, input dc, input sel);
        integer   i;
        reg [16:0] nz;
        begin
            @(posedge sys_clk);
            chip_select_n <= ~sel;
            write_strobe_n <= dc;
            for (i = n - 1; i >= 0; i = i - 1) begin
                nz = $urandom;
                dataIn <= {nz, b[i]};
                repeat (3) @(posedge sys_clk);
                data_command_select <= 1'b1;
                repeat (3) @(posedge sys_clk);
                data_command_select <= 1'b0;
            end
            repeat (3) @(posedge sys_clk);
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            dataIn <= ~dataIn;
        end
    endtask
endmodule

// file: testbench/tb_host_port_strap_decode.sv
`timescale 1ns/100ps
module tb_host_port_strap_decode;
    // Bench-driven inputs
    logic        sys_clk, sys_rst, chip_reset_n, readDataValid;
    logic        tearingEnable, tearingLevel, oscMonEnable, oscClkLevel;
    logic [17:0] readData;
    logic [2:0]  panel_size_strap;
    logic        interface_class_strap, parallel_width_strap_hi, parallel_width_strap_lo, serial_wire_count_strap;
    logic        sync_line_count_strap, extended_command_enable, source_scan_reverse, gate_scan_reverse;
    logic        filter_order_swap, liquid_crystal_polarity, gamma_curve_strap;
    // Host pins and design outputs
    wire         chip_select_n, data_command_select, read_strobe_n, write_strobe_n;
    wire  [17:0] dataIn, dataOut, dataOe, xferWord;
    wire         xferIsData, xferValid, xferReadReq, tearing_sync_out, oscMonOut, extCmdEn_r, panelReduced_r;
    wire  [2:0]  busMode_r;
    wire  [8:0]  srcFirst_r, srcLast_r;
    wire  [7:0]  gateFirst_r, gateLast_r, syncLines_r;
    wire  [4:0]  gammaEntry0_r, gammaEntry1_r;
    wire         bgrOrder_r, normBlack_r, cfgValid_r;
    int          errors, comparisons, rdCnt;
    logic [18:0] q[$];

    hpsd_host_port_strap_decode i_dut (.*);
    hpsd_host_model i_host (.*);

    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task chk(input string n, input logic [17:0] s, input logic [17:0] x);
        begin
            comparisons++;
            if (s !== x) begin
                errors++;
                $display("[ERR] %s expected %h seen %h", n, x, s);
            end
        end
    endtask

    task results;
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // Random core controls keep tearing and monitor gating busy
    always @(posedge sys_clk) {tearingEnable, tearingLevel, oscMonEnable, oscClkLevel} <= 4'($urandom);

    // Every received transfer must match the oldest expected one
    always @(posedge sys_clk) begin
        if (xferReadReq === 1'b1) rdCnt++;
        if (xferValid === 1'b1 && q.size() == 0) chk("spurious xfer", 18'h1, 18'h0);
        else if (xferValid === 1'b1) begin
            chk("xferWord", xferWord, q[0][17:0]);
            chk("xferIsData", xferIsData, q[0][18]);
            void'(q.pop_front());
        end
    end

    // Hang guard
    initial begin
        #400000;
        chk("timeout", 18'h1, 18'h0);
        results;
    end

    initial begin
        int k, j;
        logic [2:0] bm;
        logic [8:0] sf, sl;
        logic [7:0] gf, gl;
        logic [17:0] w, mask;
        logic red, dc;
        void'($urandom(32'h6d757379));
        {sys_rst, chip_reset_n, readDataValid, readData, panel_size_strap} = {3'h6, 18'h00000, 3'h0};
        {interface_class_strap, parallel_width_strap_hi, parallel_width_strap_lo, serial_wire_count_strap} = 4'h0;
        {sync_line_count_strap, extended_command_enable, source_scan_reverse, gate_scan_reverse} = 4'h0;
        {filter_order_swap, liquid_crystal_polarity, gamma_curve_strap, tearingEnable, tearingLevel} = 5'h00;
        {oscMonEnable, oscClkLevel, errors, comparisons, rdCnt} = 0;
        for (k = 0; k < 6; k++) begin
            bm = (k < 2) ? 3'(k) : 3'(k + 2);
            @(posedge sys_clk);
            if (k % 2) chip_reset_n <= 1'b0;
            else sys_rst <= 1'b1;
            // Straps move only once the block or pin reset has cleared the latch
            repeat (3) @(posedge sys_clk);
            {interface_class_strap, parallel_width_strap_hi, parallel_width_strap_lo} <= bm;
            serial_wire_count_strap <= bm[0];
            {sync_line_count_strap, extended_command_enable, source_scan_reverse, gate_scan_reverse} <= 4'($urandom);
            {filter_order_swap, liquid_crystal_polarity, gamma_curve_strap} <= 3'($urandom);
            panel_size_strap <= (k < 2) ? 3'(k * 3) : 3'($urandom);
            repeat (8) @(posedge sys_clk);
            #1 chk("cfgValid in reset", cfgValid_r, 18'h0);
            {sys_rst, chip_reset_n} <= 2'b01;
            for (j = 0; j < 40 && cfgValid_r !== 1'b1; j++) @(posedge sys_clk);
            #1 chk("cfgValid", cfgValid_r, 18'h1);
            mask = bm == 3'h5 ? 18'h0FFFF : bm == 3'h6 ? 18'h001FF : bm == 3'h7 ? 18'h3FFFF : 18'h000FF;
            red = panel_size_strap != 3'h0;
            {sf, sl, gf, gl} = red ? {9'h007, 9'h186, 8'h02, 8'hA1} : {9'h001, 9'h18C, 8'h01, 8'hA2};
            chk("busMode", busMode_r, bm);
            chk("extCmd", extCmdEn_r, extended_command_enable);
            chk("srcFirst", srcFirst_r, source_scan_reverse ? sl : sf);
            chk("srcLast", srcLast_r, source_scan_reverse ? sf : sl);
            chk("gateFirst", gateFirst_r, gate_scan_reverse ? gl : gf);
            chk("gateLast", gateLast_r, gate_scan_reverse ? gf : gl);
            chk("syncLines", syncLines_r, (red || sync_line_count_strap) ? 8'hA0 : 8'hA2);
            chk("bgr", bgrOrder_r, filter_order_swap);
            chk("normBlack", normBlack_r, liquid_crystal_polarity);
            chk("gamma0", gammaEntry0_r, gamma_curve_strap ? 5'h16 : 5'h0A);
            chk("gamma1", gammaEntry1_r, gamma_curve_strap ? 5'h12 : 5'h19);
            // Two accepted writes, then one with chip select high
            for (j = 0; j < 3; j++) begin
                w = 18'($urandom);
                dc = j[0];
                if (j < 2) q.push_back({dc, w & mask});
                if (bm[2]) i_host.par(w, dc, 1'b0, j < 2);
                else if (bm[0]) i_host.ser({1'b0, w[7:0]}, 4'h8, dc, j < 2);
                else i_host.ser({dc, w[7:0]}, 4'h9, 1'b1, j < 2);
                for (int t = 0; t < 20 && q.size() != 0; t++) @(posedge sys_clk);
                chk("pending", 18'(q.size()), 18'h0);
            end
            repeat (8) @(posedge sys_clk);
            if (bm[2]) begin
                readData <= 18'($urandom);
                rdCnt = 0;
                fork
                    i_host.par(w, 1'b0, 1'b1, 1'b1);
                    begin
                        repeat (7) @(posedge sys_clk);
                        #1 chk("readOut", dataOut & mask, readData & mask);
                        chk("readOe", 18'(dataOe != 18'h0), 18'h1);
                    end
                join
                repeat (6) @(posedge sys_clk);
                chk("readOeOff", dataOe, 18'h0);
                chk("readReq", 18'(rdCnt), 18'h1);
            end
            $display("test mode %0d done", bm);
        end
        results;
    end
endmodule
